// *** test/rsc_strap_board.sv ***
// Purpose: Board strap resistors that the hub samples at reset release.
// Assumes: The bench picks one resistor per strap pin through tie.
// Notes:   For one cycle after any change to tie, every pin shows the inverse level.
`timescale 1ns/1ns
`default_nettype none
module rsc_strap_board (
    // Clock.
    input  wire logic                 clk,
    // Chosen resistors.
    input  wire rsc_pkg::rsc_straps_t tie,
    // Strap pins.
    output var  rsc_pkg::rsc_straps_t straps
);
    rsc_pkg::rsc_straps_t last_q;
    always_ff @(posedge clk) begin
        last_q <= tie;
    end
    always_comb begin
        straps = (last_q == tie) ? tie : ~tie;
    end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the strap latch and its register view.
// Assumes: Straps are set at least two cycles before reset ends.
// Notes:   Straps are inverted after capture to show that they are held.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                 clk, srst, ext_reset_n, psel, penable, pwrite, pready, pslverr, er;
    logic                 cfg_valid, bm, ss;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd, seed, r;
    logic [5:0]           hs_off, ss_off, fx_p, cg_p;
    rsc_pkg::rsc_straps_t tie, straps, cap;
    int                   num_errors, num_checks;

    rsc_strap_board board (.clk(clk), .tie(tie), .straps(straps));
    rsc_strap_latch dut (.clk(clk), .srst(srst), .ext_reset_n(ext_reset_n), .straps(straps),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_valid(cfg_valid),
        .bridge_master_setting(bm), .sideband_slave_setting(ss), .port_hs_off(hs_off),
        .port_ss_off(ss_off), .fixed_ports(fx_p), .charging_ports(cg_p));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [5:0] lmask(input logic [2:0] c);
        return (c < 3'h5) ? 6'((7'h01 << c) - 7'h01) : ((c == 3'h5) ? 6'h3F : 6'h00);
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Called right after a rising edge; leaves right after one.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) num_errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk_cfg(input logic [5:0] ovr);
        logic [5:0] off, fx, cg;
        off = (cap.dplus_off & cap.dminus_off) | ovr;
        fx = lmask(cap.fixed);
        cg = lmask(cap.charge);
        chk("valid", 32'h1, 32'(cfg_valid));
        chk("master", 32'(cap.mode == 3'h0), 32'(bm));
        chk("slave", 32'(cap.mode == 3'h1), 32'(ss));
        chk("hs_off", 32'(off), 32'(hs_off));
        chk("ss_off", 32'(off), 32'(ss_off));
        chk("fixed", 32'(fx), 32'(fx_p));
        chk("charge", 32'(cg), 32'(cg_p));
        apb(1'b0, rsc_pkg::ADDR_STATUS, rsc_pkg::DATA_ZERO);
        chk("status", {20'h0, cap.mode == 3'h1, cap.mode == 3'h0, 1'b1, cap.charge, cap.fixed,
            cap.mode}, rd);
        apb(1'b0, rsc_pkg::ADDR_PORTS, rsc_pkg::DATA_ZERO);
        chk("ports", {14'h0, cg, fx, off}, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        srst = 1'b1;
        ext_reset_n = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 32'h68FF;
        num_errors = 0;
        num_checks = 0;
        for (int m = 0; m < 8; m++) begin
            r = nxt();
            tie <= {3'(m), 3'(7 - m), 3'(m + 3), (m == 0) ? 12'hFFF : r[11:0]};
            if (m[0]) ext_reset_n <= 1'b0;
            else if (m != 0) srst <= 1'b1;
            repeat (3) @(posedge clk);
            chk("cleared", 32'h0, 32'(cfg_valid));
            srst <= 1'b0;
            ext_reset_n <= 1'b1;
            cap = tie;
            @(posedge clk);
            tie <= ~tie;
            @(posedge clk);
            chk_cfg(rsc_pkg::OVR_RESET);
            r = nxt();
            apb(1'b1, rsc_pkg::ADDR_OVR, 32'(r[5:0]));
            apb(1'b1, rsc_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
            apb(1'b0, rsc_pkg::ADDR_OVR, rsc_pkg::DATA_ZERO);
            chk("ovr", 32'(r[5:0]), rd);
            chk("mapped err", 32'h0, 32'(er));
            chk_cfg(r[5:0]);
            apb(1'b0, 8'h0C, rsc_pkg::DATA_ZERO);
            chk("unmapped err", 32'h1, 32'(er));
            chk("unmapped data", 32'h0, rd);
        end
        conclude();
    end
endmodule
`default_nettype wire

// *** verilog/rsc_level_mask.sv ***
// Purpose: Turns a resolved strap level into a mask of the lowest ports.
// Assumes: Level codes six and seven do not occur; they decode as no ports.
// Notes:   Used for both the fixed-port and the charging-port straps.
`timescale 1ns/1ns
`default_nettype none
module rsc_level_mask #(
    parameter int NPORTS = rsc_pkg::NUM_PORTS
) (
    // Level in.
    input  wire logic [2:0]        code,
    // Mask out.
    output logic      [NPORTS-1:0] mask
);

    logic [2:0] count;

    always_comb begin
        unique case (code)
            rsc_pkg::LVL_200K_PD: count = rsc_pkg::CNT_L0;
            rsc_pkg::LVL_200K_PU: count = rsc_pkg::CNT_L1;
            rsc_pkg::LVL_10K_PD:  count = rsc_pkg::CNT_L2;
            rsc_pkg::LVL_10K_PU:  count = rsc_pkg::CNT_L3;
            rsc_pkg::LVL_10R_PD:  count = rsc_pkg::CNT_L4;
            rsc_pkg::LVL_10R_PU:  count = rsc_pkg::CNT_L5;
            default:              count = rsc_pkg::CNT_L0;
        endcase
    end

    always_comb begin
        for (int i = 0; i < NPORTS; i++) begin
            mask[i] = (i < int'(count));
        end
    end

endmodule
`default_nettype wire

// *** verilog/rsc_pkg.sv ***
// Purpose: Shared constants and types for the reset strap configuration latch.
// Assumes: Strap levels arrive already resolved to a 3-bit level code.
// Notes:   Level codes follow the resistor order of the strap tables, 200k pull-down first.
`default_nettype none
package rsc_pkg;

    localparam int          NUM_PORTS  = 6;
    localparam int          CODE_W     = 3;
    localparam int          CNT_W      = 3;

    // Resolved strap levels, weakest pull-down (200k PD) first.
    localparam logic [2:0]  LVL_200K_PD = 3'h0;
    localparam logic [2:0]  LVL_200K_PU = 3'h1;
    localparam logic [2:0]  LVL_10K_PD  = 3'h2;
    localparam logic [2:0]  LVL_10K_PU  = 3'h3;
    localparam logic [2:0]  LVL_10R_PD  = 3'h4;
    localparam logic [2:0]  LVL_10R_PU  = 3'h5;

    // Port counts selected by each level, in level order.
    localparam logic [2:0]  CNT_L0 = 3'h0;
    localparam logic [2:0]  CNT_L1 = 3'h1;
    localparam logic [2:0]  CNT_L2 = 3'h2;
    localparam logic [2:0]  CNT_L3 = 3'h3;
    localparam logic [2:0]  CNT_L4 = 3'h4;
    localparam logic [2:0]  CNT_L5 = 3'h6;

    // Register map, byte addresses.
    localparam logic [7:0]  ADDR_STATUS = 8'h00;
    localparam logic [7:0]  ADDR_PORTS  = 8'h04;
    localparam logic [7:0]  ADDR_OVR    = 8'h08;

    // STATUS fields.
    localparam int          ST_MODE_LSB   = 0;
    localparam int          ST_FIXED_LSB  = 3;
    localparam int          ST_CHARGE_LSB = 6;
    localparam int          ST_VALID_BIT  = 9;
    localparam int          ST_MASTER_BIT = 10;
    localparam int          ST_SLAVE_BIT  = 11;
    // PORTS fields.
    localparam int          PT_OFF_LSB    = 0;
    localparam int          PT_FIXED_LSB  = 6;
    localparam int          PT_CHARGE_LSB = 12;

    localparam logic [5:0]  OVR_RESET  = 6'h00;
    localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

    typedef enum logic [1:0] {
        RSC_SB_MASTER,
        RSC_SB_SLAVE,
        RSC_SB_RESERVED
    } rsc_sb_mode_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] fixed;
        logic [2:0] charge;
        logic [5:0] dplus_off;
        logic [5:0] dminus_off;
    } rsc_straps_t;

endpackage
`default_nettype wire

// *** verilog/rsc_strap_latch.sv ***
// Purpose: Captures hub strap pins at reset release and decodes hub settings.
// Assumes: Straps are stable and resolved to level codes before release.
// Notes:   An override register lets firmware disable further ports.
// How it works
// - Sample straps once at reset release, hold.
// - Weakest pull-down mode selects sideband master.
// - Weak pull-up mode selects sideband slave.
// - Port disabled only when both straps high; the override register can also disable a port.
// - Disabled legacy path also disables SuperSpeed path.
// - Fixed strap level selects non-removable port count.
// - Charging strap level selects charging-enabled ports.
// - Charging levels map none, 1, 1-2, 1-3, 1-4, all.
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module rsc_strap_latch #(
    parameter int NPORTS = rsc_pkg::NUM_PORTS
) (
    // Clock and resets.
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 ext_reset_n,
    // Strap pins.
    input  wire rsc_pkg::rsc_straps_t straps,
    // APB slave.
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Decoded configuration.
    output logic                      cfg_valid,
    output logic                      bridge_master_setting,
    output logic                      sideband_slave_setting,
    output logic      [NPORTS-1:0]    port_hs_off,
    output logic      [NPORTS-1:0]    port_ss_off,
    output logic      [NPORTS-1:0]    fixed_ports,
    output logic      [NPORTS-1:0]    charging_ports
);

    ////////////////////////////////////////////////////////////////////////////////
    // Strap capture and decode.

    logic                 in_reset;
    logic                 valid_q, valid_d;
    rsc_pkg::rsc_straps_t raw_q, raw_d;
    rsc_pkg::rsc_sb_mode_t sb_mode;
    logic [NPORTS-1:0]    fixed_mask, charge_mask;
    logic [NPORTS-1:0]    off_q, off_d, fixed_q, fixed_d, charge_q, charge_d;
    logic                 master_q, master_d, slave_q, slave_d;
    logic [5:0]           ovr_q, ovr_d;

    assign in_reset = srst | ~ext_reset_n;

    rsc_level_mask #(.NPORTS(NPORTS)) u_fixed (
        .code (raw_d.fixed),
        .mask (fixed_mask)
    );

    rsc_level_mask #(.NPORTS(NPORTS)) u_charge (
        .code (raw_d.charge),
        .mask (charge_mask)
    );

    always_comb begin
        unique case (raw_d.mode)
            rsc_pkg::LVL_200K_PD: sb_mode = rsc_pkg::RSC_SB_MASTER;
            rsc_pkg::LVL_200K_PU: sb_mode = rsc_pkg::RSC_SB_SLAVE;
            default:              sb_mode = rsc_pkg::RSC_SB_RESERVED;
        endcase
    end

    always_comb begin
        valid_d  = valid_q;
        raw_d    = raw_q;
        if (in_reset) begin
            valid_d = 1'b0;
            raw_d   = '0;
        end else if (!valid_q) begin
            valid_d = 1'b1;
            raw_d   = straps;
        end
        master_d = valid_d && (sb_mode == rsc_pkg::RSC_SB_MASTER);
        slave_d  = valid_d && (sb_mode == rsc_pkg::RSC_SB_SLAVE);
        off_d    = (raw_d.dplus_off[NPORTS-1:0] & raw_d.dminus_off[NPORTS-1:0])
                 | ovr_d[NPORTS-1:0];
        fixed_d  = valid_d ? fixed_mask : '0;
        charge_d = valid_d ? charge_mask : '0;
    end

    always_ff @(posedge clk) begin
        valid_q  <= valid_d;
        raw_q    <= raw_d;
        master_q <= master_d;
        slave_q  <= slave_d;
        off_q    <= off_d;
        fixed_q  <= fixed_d;
        charge_q <= charge_d;
    end

    assign cfg_valid              = valid_q;
    assign bridge_master_setting  = master_q;
    assign sideband_slave_setting = slave_q;
    assign port_hs_off            = off_q;
    assign port_ss_off            = off_q;
    assign fixed_ports            = fixed_q;
    assign charging_ports         = charge_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB register slave.

    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic        setup, wr_commit, mapped;

    assign setup     = psel && !penable;
    assign wr_commit = psel && penable && pready_q && pwrite;
    assign mapped    = (paddr == rsc_pkg::ADDR_STATUS) || (paddr == rsc_pkg::ADDR_PORTS)
                    || (paddr == rsc_pkg::ADDR_OVR);

    always_comb begin
        ovr_d     = ovr_q;
        prdata_d  = rsc_pkg::DATA_ZERO;
        pready_d  = setup;
        pslverr_d = setup && !mapped;
        if (in_reset) begin
            ovr_d = rsc_pkg::OVR_RESET;
        end else if (wr_commit && paddr == rsc_pkg::ADDR_OVR) begin
            ovr_d = pwdata[5:0];
        end
        if (setup && !pwrite) begin
            unique case (paddr)
                rsc_pkg::ADDR_STATUS: begin
                    prdata_d[rsc_pkg::ST_MODE_LSB +: 3]   = raw_q.mode;
                    prdata_d[rsc_pkg::ST_FIXED_LSB +: 3]  = raw_q.fixed;
                    prdata_d[rsc_pkg::ST_CHARGE_LSB +: 3] = raw_q.charge;
                    prdata_d[rsc_pkg::ST_VALID_BIT]       = valid_q;
                    prdata_d[rsc_pkg::ST_MASTER_BIT]      = master_q;
                    prdata_d[rsc_pkg::ST_SLAVE_BIT]       = slave_q;
                end
                rsc_pkg::ADDR_PORTS: begin
                    prdata_d[rsc_pkg::PT_OFF_LSB +: NPORTS]    = off_q;
                    prdata_d[rsc_pkg::PT_FIXED_LSB +: NPORTS]  = fixed_q;
                    prdata_d[rsc_pkg::PT_CHARGE_LSB +: NPORTS] = charge_q;
                end
                rsc_pkg::ADDR_OVR: prdata_d[5:0] = ovr_q;
                default:           prdata_d = rsc_pkg::DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= rsc_pkg::DATA_ZERO;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
        ovr_q <= ovr_d;
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence release_s;
        $past(in_reset) && !in_reset;
    endsequence

    sequence captured_s;
        valid_q && (raw_q == $past(straps));
    endsequence

    capture_at_release_a: assert property (release_s |=> captured_s)
        else $error("Straps not captured at reset release.");

    capture_held_a: assert property (valid_q && !in_reset |=> $stable(raw_q))
        else $error("Captured straps changed without reset.");

    master_mode_a: assert property (
        valid_q |-> bridge_master_setting == (raw_q.mode == rsc_pkg::LVL_200K_PD))
        else $error("Master setting does not follow mode strap.");

    slave_mode_a: assert property (
        valid_q |-> sideband_slave_setting == (raw_q.mode == rsc_pkg::LVL_200K_PU))
        else $error("Slave setting does not follow mode strap.");

    reserved_mode_a: assert property (raw_q.mode > rsc_pkg::LVL_200K_PU
        |-> !bridge_master_setting && !sideband_slave_setting)
        else $error("Reserved mode drives a sideband setting.");

    port_disable_a: assert property (valid_q |-> port_hs_off ==
        ((raw_q.dplus_off[NPORTS-1:0] & raw_q.dminus_off[NPORTS-1:0]) | ovr_q[NPORTS-1:0]))
        else $error("Port disable does not match strap pair.");

    ss_follow_a: assert property (port_ss_off == port_hs_off)
        else $error("SuperSpeed path not disabled with legacy path.");

    fixed_top_a: assert property (
        valid_q && raw_q.fixed == rsc_pkg::LVL_10R_PU |-> fixed_ports == {NPORTS{1'b1}})
        else $error("Fixed ports wrong for strongest pull-up.");

    fixed_none_a: assert property (
        valid_q && raw_q.fixed == rsc_pkg::LVL_200K_PD |-> fixed_ports == '0)
        else $error("Fixed ports wrong for weakest pull-down.");

    charge_map_a: assert property (valid_q && raw_q.charge == rsc_pkg::LVL_10R_PD
        |-> charging_ports == NPORTS'(4'hF))
        else $error("Charging ports wrong for four-port level.");

    apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("APB answer not one cycle after setup.");

endmodule
`default_nettype wire
